// ---- cpf_pkg.sv ----
// Package with constants and types for the core sequencing and status datapath.
// Summary of operation
// - Eight-bit accumulator between arithmetic unit and memory.
// - Operations update zero, carry, nibble carry flags.
// - Accumulator has no data memory address.
// - Fifteen-bit program counter, seven high, eight low.
// - Counter advances one step per instruction.
// - Jump or call loads bits zero to fourteen.
// - Jump and call occupy two program words.
// - Five skip instructions skip when condition true.
// - True bit test advances counter two steps.
// - Increment wrap to zero skips next instruction.
// - Decrement wrap to all ones skips next.
// - Add to low byte gives table jump.
// - One program page spans 256 words.
// - Flag bits seven, six encode reset cause.
// - Flag bit five shows high undervolt status.
// - Flag bit four shows middle undervolt status.
// - Carry flag in bit two per operation.
// - Nibble carry flag in bit one.
// - Zero flag in bit zero on zero result.
// - Pointer bytes are eight-bit general or pointer.
package cpf_pkg;

  // ********************************************************************
  // Register map.
  // ********************************************************************
  localparam logic [7:0] CPF_IDX_PTR_LOW   = 8'h80;
  localparam logic [7:0] CPF_IDX_PTR_HIGH  = 8'h81;
  localparam logic [7:0] CPF_IDX_FLAGS     = 8'h86;
  localparam logic [7:0] CPF_IDX_ACC       = 8'h40;
  localparam logic [7:0] CPF_IDX_PC        = 8'h41;
  localparam logic [7:0] CPF_IDX_CMD       = 8'h42;
  localparam logic [7:0] CPF_IDX_CTRL      = 8'h43;
  localparam logic [7:0] CPF_IDX_LAST      = 8'h44;

  // ********************************************************************
  // Field positions and widths.
  // ********************************************************************
  localparam int CPF_PC_W       = 15;
  localparam int CPF_PCH_W      = 6;
  localparam int CPF_DATA_W     = 8;
  localparam int CPF_FLAG_Z     = 0;
  localparam int CPF_FLAG_NCARRY = 1;
  localparam int CPF_FLAG_C     = 2;
  localparam int CPF_FLAG_MID   = 4;
  localparam int CPF_FLAG_HIGH  = 5;
  localparam int CPF_FLAG_RLO   = 6;
  localparam int CPF_FLAG_RHI   = 7;
  localparam int CPF_CMD_OP_LSB = 16;
  localparam int CPF_CMD_BIT_LSB = 8;
  localparam int CPF_CTRL_OPT_HIGH = 0;
  localparam int CPF_CTRL_OPT_MID  = 1;
  localparam logic [7:0] CPF_BYTE_ZERO = 8'h00;
  localparam logic [7:0] CPF_BYTE_ONES = 8'hff;
  localparam logic [14:0] CPF_PC_RESET = 15'h0000;
  localparam logic [14:0] CPF_STEP_ONE = 15'h0001;
  localparam logic [14:0] CPF_STEP_TWO = 15'h0002;

  // ********************************************************************
  // Reset causes.
  // ********************************************************************
  typedef enum logic [1:0] {
    CPF_RST_WATCHDOG = 2'b00,
    CPF_RST_RESERVED = 2'b01,
    CPF_RST_UNDERVOLT = 2'b10,
    CPF_RST_PIN = 2'b11
  } cpf_rst_cause_t;

  // ********************************************************************
  // Operation codes written to the command register.
  // ********************************************************************
  typedef enum logic [3:0] {
    CPF_OP_NOP       = 4'h0,
    CPF_OP_ADD       = 4'h1,
    CPF_OP_SUB       = 4'h2,
    CPF_OP_RLC       = 4'h3,
    CPF_OP_AND       = 4'h4,
    CPF_OP_JUMP      = 4'h5,
    CPF_OP_CMP_SKIP  = 4'h6,
    CPF_OP_INC_SKIP  = 4'h7,
    CPF_OP_DEC_SKIP  = 4'h8,
    CPF_OP_BT0_SKIP  = 4'h9,
    CPF_OP_BT1_SKIP  = 4'ha,
    CPF_OP_ADD_PAGE  = 4'hb,
    CPF_OP_MOV_ACC   = 4'hc
  } cpf_op_t;

  typedef struct packed {
    logic       z;
    logic       nibble_carry;
    logic       c;
  } cpf_alu_flags_t;

endpackage

// ---- cpf_core.sv ----
// Accumulator, program counter and flag datapath with an APB register port.
`timescale 1ns/1ps
module cpf_core
  import cpf_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  input  wire logic [1:0]        reset_cause,
  input  wire logic              undervolt_high_det,
  input  wire logic              undervolt_mid_det,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic [14:0]            instr_pointer,
  output logic [7:0]             work_reg_a
);

  // ********************************************************************
  // Registers.
  // ********************************************************************
  logic [14:0]    pc_reg;
  logic [14:0]    pc_next;
  logic [7:0]     acc_reg;
  logic [7:0]     acc_next;
  logic [7:0]     ptr_low_reg;
  logic [7:0]     ptr_high_reg;
  logic [7:0]     mem_next;
  cpf_alu_flags_t flags_reg;
  cpf_alu_flags_t flags_next;
  logic [1:0]     cause_reg;
  logic           cause_loaded_reg;
  logic [1:0]     opt_reg;
  logic           high_reg;
  logic           mid_reg;
  logic [7:0]     last_reg;
  logic [31:0]    prdata_reg;
  logic           pready_reg;
  logic           pslverr_reg;

  // ********************************************************************
  // Bus decode.
  // ********************************************************************
  wire         setup_w   = psel & ~penable;
  wire         access_w  = psel & penable & pready_reg;
  wire [9:0]   idx_w     = paddr[11:2];
  wire         hit_low   = (idx_w == {2'b00, CPF_IDX_PTR_LOW});
  wire         hit_high  = (idx_w == {2'b00, CPF_IDX_PTR_HIGH});
  wire         hit_flag  = (idx_w == {2'b00, CPF_IDX_FLAGS});
  wire         hit_acc   = (idx_w == {2'b00, CPF_IDX_ACC});
  wire         hit_pc    = (idx_w == {2'b00, CPF_IDX_PC});
  wire         hit_cmd   = (idx_w == {2'b00, CPF_IDX_CMD});
  wire         hit_ctrl  = (idx_w == {2'b00, CPF_IDX_CTRL});
  wire         hit_last  = (idx_w == {2'b00, CPF_IDX_LAST});
  wire         hit_any   = hit_low | hit_high | hit_flag | hit_acc | hit_pc | hit_cmd
                           | hit_ctrl | hit_last;
  wire         bad_w     = (paddr[1:0] != 2'b00) | ~hit_any;
  wire         wr_w      = access_w & pwrite & pstrb[0] & ~bad_w;

  // ********************************************************************
  // Command fields: operand byte, bit number, target select, opcode.
  // ********************************************************************
  wire         cmd_w     = wr_w & hit_cmd & ~bad_w;
  wire [7:0]   opnd_w    = pwdata[7:0];
  wire [2:0]   bit_w     = pwdata[CPF_CMD_BIT_LSB +: 3];
  wire [1:0]   tgt_w     = pwdata[CPF_CMD_BIT_LSB+4 +: 2];
  wire [3:0]   op_w      = pwdata[CPF_CMD_OP_LSB +: 4];
  wire [14:0]  dest_w    = pwdata[CPF_CMD_OP_LSB+8 +: 8] == CPF_BYTE_ZERO ?
                           {7'h00, opnd_w} : {pwdata[30:24], opnd_w};

  // Selects the memory operand: pointer low, pointer high or immediate byte.
  function automatic logic [7:0] pick(input logic [1:0] t, input logic [7:0] lo,
                                      input logic [7:0] hi, input logic [7:0] imm);
    case (t)
      2'b01: pick = lo;
      2'b10: pick = hi;
      default: pick = imm;
    endcase
  endfunction

  wire [7:0]   src_w     = pick(tgt_w, ptr_low_reg, ptr_high_reg, opnd_w);
  wire [7:0]   step_src_w = (tgt_w == 2'b00) ? acc_reg : src_w;
  wire [8:0]   sum_w     = {1'b0, acc_reg} + {1'b0, src_w};
  wire [4:0]   nsum_w    = {1'b0, acc_reg[3:0]} + {1'b0, src_w[3:0]};
  wire [8:0]   dif_w     = {1'b0, acc_reg} - {1'b0, src_w};
  wire [4:0]   ndif_w    = {1'b0, acc_reg[3:0]} - {1'b0, src_w[3:0]};
  wire [7:0]   inc_w     = step_src_w + 8'h01;
  wire [7:0]   dec_w     = step_src_w - 8'h01;
  wire         bit_v_w   = src_w[bit_w];
  wire [7:0]   page_sum_w = pc_reg[7:0] + acc_reg;

  // ********************************************************************
  // Next-state logic for operations.
  // ********************************************************************
  always_comb begin
    pc_next    = pc_reg + CPF_STEP_ONE;
    acc_next   = acc_reg;
    mem_next   = src_w;
    flags_next = flags_reg;
    case (cpf_op_t'(op_w))
      CPF_OP_ADD: begin
        acc_next      = sum_w[7:0];
        flags_next.c  = sum_w[8];
        flags_next.nibble_carry = nsum_w[4];
        flags_next.z  = (sum_w[7:0] == CPF_BYTE_ZERO);
      end
      CPF_OP_SUB: begin
        acc_next      = dif_w[7:0];
        flags_next.c  = ~dif_w[8];
        flags_next.nibble_carry = ~ndif_w[4];
        flags_next.z  = (dif_w[7:0] == CPF_BYTE_ZERO);
      end
      CPF_OP_RLC: begin
        acc_next      = {acc_reg[6:0], flags_reg.c};
        flags_next.c  = acc_reg[7];
      end
      CPF_OP_AND: begin
        acc_next      = acc_reg & src_w;
        flags_next.z  = ((acc_reg & src_w) == CPF_BYTE_ZERO);
      end
      CPF_OP_JUMP: begin
        pc_next = dest_w;
      end
      CPF_OP_CMP_SKIP: begin
        flags_next.c = ~dif_w[8];
        flags_next.z = (acc_reg == src_w);
        if (acc_reg == src_w) begin
          pc_next = pc_reg + CPF_STEP_TWO;
        end
      end
      CPF_OP_INC_SKIP: begin
        mem_next = inc_w;
        if (tgt_w == 2'b00) begin
          acc_next = inc_w;
        end
        if (inc_w == CPF_BYTE_ZERO) begin
          pc_next = pc_reg + CPF_STEP_TWO;
        end
      end
      CPF_OP_DEC_SKIP: begin
        mem_next = dec_w;
        if (tgt_w == 2'b00) begin
          acc_next = dec_w;
        end
        if (dec_w == CPF_BYTE_ONES) begin
          pc_next = pc_reg + CPF_STEP_TWO;
        end
      end
      CPF_OP_BT0_SKIP: begin
        if (!bit_v_w) begin
          pc_next = pc_reg + CPF_STEP_TWO;
        end
      end
      CPF_OP_BT1_SKIP: begin
        if (bit_v_w) begin
          pc_next = pc_reg + CPF_STEP_TWO;
        end
      end
      CPF_OP_ADD_PAGE: begin
        pc_next = {pc_reg[14:8], page_sum_w};
      end
      CPF_OP_MOV_ACC: begin
        acc_next = opnd_w;
      end
      default: begin
        pc_next = pc_reg + CPF_STEP_ONE;
      end
    endcase
  end

  wire mem_wr_w = cmd_w & ((op_w == CPF_OP_INC_SKIP) | (op_w == CPF_OP_DEC_SKIP));

  // ********************************************************************
  // Program counter and accumulator.
  // ********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg  <= CPF_PC_RESET;
      acc_reg <= CPF_BYTE_ZERO;
    end else if (cmd_w) begin
      pc_reg  <= pc_next;
      acc_reg <= acc_next;
    end else if (wr_w & hit_pc) begin
      pc_reg  <= pwdata[14:0];
    end else if (wr_w & hit_acc) begin
      acc_reg <= pwdata[7:0];
    end
  end

  // ********************************************************************
  // Pointer bytes.
  // ********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_low_reg  <= CPF_BYTE_ZERO;
      ptr_high_reg <= CPF_BYTE_ZERO;
    end else begin
      if ((wr_w & hit_low) | (mem_wr_w & (tgt_w == 2'b01))) begin
        ptr_low_reg <= hit_low ? pwdata[7:0] : mem_next;
      end
      if ((wr_w & hit_high) | (mem_wr_w & (tgt_w == 2'b10))) begin
        ptr_high_reg <= hit_high ? pwdata[7:0] : mem_next;
      end
    end
  end

  // ********************************************************************
  // Flags, reset cause, undervolt status and options.
  // ********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg        <= '0;
      cause_reg        <= CPF_RST_PIN;
      cause_loaded_reg <= 1'b0;
      opt_reg          <= 2'b00;
      high_reg         <= 1'b0;
      mid_reg          <= 1'b0;
    end else begin
      if (!cause_loaded_reg) begin
        cause_reg        <= reset_cause;
        cause_loaded_reg <= 1'b1;
      end else if (wr_w & hit_flag) begin
        cause_reg <= pwdata[CPF_FLAG_RHI:CPF_FLAG_RLO];
      end
      if (cmd_w) begin
        flags_reg <= flags_next;
      end else if (wr_w & hit_flag) begin
        flags_reg <= {pwdata[CPF_FLAG_Z], pwdata[CPF_FLAG_NCARRY], pwdata[CPF_FLAG_C]};
      end
      if (wr_w & hit_ctrl) begin
        opt_reg <= pwdata[1:0];
      end
      high_reg <= opt_reg[CPF_CTRL_OPT_HIGH] & undervolt_high_det;
      mid_reg  <= opt_reg[CPF_CTRL_OPT_MID] & undervolt_mid_det;
    end
  end

  wire [7:0] flag_byte_w = {cause_reg, high_reg, mid_reg, 1'b0,
                            flags_reg.c, flags_reg.nibble_carry, flags_reg.z};

  // ********************************************************************
  // Bus answer, no wait states.
  // ********************************************************************
  wire [7:0] rd_w = hit_low  ? ptr_low_reg :
                    hit_high ? ptr_high_reg :
                    hit_flag ? flag_byte_w :
                    hit_acc  ? acc_reg :
                    hit_ctrl ? {6'h00, opt_reg} :
                    hit_last ? last_reg : CPF_BYTE_ZERO;
  wire [31:0] rd32_w = hit_pc ? {17'h00000, pc_reg} : {24'h000000, rd_w};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
      last_reg    <= CPF_BYTE_ZERO;
    end else begin
      pready_reg  <= setup_w;
      pslverr_reg <= setup_w & bad_w;
      prdata_reg  <= (setup_w & ~pwrite & ~bad_w) ? rd32_w : 32'h00000000;
      if (cmd_w) begin
        last_reg <= {4'h0, op_w};
      end
    end
  end

  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign instr_pointer = pc_reg;
  assign work_reg_a    = acc_reg;

  // ********************************************************************
  // Checks.
  // ********************************************************************
  pc_reset_zero_a: assert property (@(posedge pclk)
      $rose(presetn)
      |-> pc_reg == CPF_PC_RESET)
    else $error("Program counter not zero after reset.");
  cause_load_a: assert property (@(posedge pclk)
      $rose(presetn)
      |=> cause_reg == $past(reset_cause))
    else $error("Reset cause not captured after reset.");
  pc_step_one_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_w && op_w == CPF_OP_NOP
      |=> pc_reg == $past(pc_reg) + CPF_STEP_ONE)
    else $error("Program counter did not advance by one.");
  pc_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      !cmd_w && !(wr_w && hit_pc)
      |=> pc_reg == $past(pc_reg))
    else $error("Program counter moved without an instruction.");
  jump_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_w && op_w == CPF_OP_JUMP
      |=> pc_reg == {$past(pwdata[30:24]), $past(pwdata[7:0])})
    else $error("Jump did not load destination.");
  cmp_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_w && op_w == CPF_OP_CMP_SKIP && acc_reg == src_w
      |=> pc_reg == $past(pc_reg) + CPF_STEP_TWO)
    else $error("Equal compare did not skip.");
  cmp_noskip_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_w && op_w == CPF_OP_CMP_SKIP && acc_reg != src_w
      |=> pc_reg == $past(pc_reg) + CPF_STEP_ONE)
    else $error("Unequal compare skipped.");
  inc_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_w && op_w == CPF_OP_INC_SKIP && step_src_w == CPF_BYTE_ONES
      |=> pc_reg == $past(pc_reg) + CPF_STEP_TWO)
    else $error("Increment wrap did not skip.");
  inc_plain_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_w && op_w == CPF_OP_INC_SKIP && step_src_w != CPF_BYTE_ONES
      |=> pc_reg == $past(pc_reg) + CPF_STEP_ONE)
    else $error("Increment without wrap skipped.");
  dec_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_w && op_w == CPF_OP_DEC_SKIP && step_src_w == CPF_BYTE_ZERO
      |=> pc_reg == $past(pc_reg) + CPF_STEP_TWO)
    else $error("Decrement wrap did not skip.");
  dec_plain_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_w && op_w == CPF_OP_DEC_SKIP && step_src_w != CPF_BYTE_ZERO
      |=> pc_reg == $past(pc_reg) + CPF_STEP_ONE)
    else $error("Decrement without wrap skipped.");
  bt0_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_w && op_w == CPF_OP_BT0_SKIP && !bit_v_w
      |=> pc_reg == $past(pc_reg) + CPF_STEP_TWO)
    else $error("Clear bit test did not skip.");
  bt1_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_w && op_w == CPF_OP_BT1_SKIP && bit_v_w
      |=> pc_reg == $past(pc_reg) + CPF_STEP_TWO)
    else $error("Set bit test did not skip.");
  page_table_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_w && op_w == CPF_OP_ADD_PAGE
      |=> pc_reg[7:0] == 8'($past(pc_reg[7:0]) + $past(acc_reg))
          && pc_reg[14:8] == $past(pc_reg[14:8]))
    else $error("Table add gave wrong low byte.");
  add_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_w && op_w == CPF_OP_ADD
      |=> flags_reg.c == (({1'b0, $past(acc_reg)} + {1'b0, $past(src_w)}) > 9'h0ff)
          && flags_reg.z == (acc_reg == CPF_BYTE_ZERO))
    else $error("Add flags wrong.");
  add_nibble_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_w && op_w == CPF_OP_ADD
      |=> flags_reg.nibble_carry == (({1'b0, $past(acc_reg[3:0])} + $past(src_w[3:0])) > 5'h0f))
    else $error("Add nibble carry wrong.");
  sub_carry_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_w && op_w == CPF_OP_SUB
      |=> flags_reg.c == ($past(acc_reg) >= $past(src_w)))
    else $error("Subtract carry wrong.");
  sub_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_w && op_w == CPF_OP_SUB
      |=> flags_reg.z == (acc_reg == CPF_BYTE_ZERO))
    else $error("Subtract zero flag wrong.");
  rlc_carry_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_w && op_w == CPF_OP_RLC
      |=> flags_reg.c == $past(acc_reg[7]) && acc_reg == {$past(acc_reg[6:0]), $past(flags_reg.c)})
    else $error("Rotate result or carry wrong.");
  and_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_w && op_w == CPF_OP_AND
      |=> flags_reg.z == (acc_reg == CPF_BYTE_ZERO))
    else $error("Logic zero flag wrong.");
  mov_acc_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_w && op_w == CPF_OP_MOV_ACC
      |=> acc_reg == $past(pwdata[7:0]))
    else $error("Immediate move did not reach the accumulator.");
  acc_hidden_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_w && (op_w == CPF_OP_INC_SKIP || op_w == CPF_OP_DEC_SKIP) && tgt_w != 2'b00
      |=> acc_reg == $past(acc_reg))
    else $error("Memory step changed the accumulator.");
  ptr_step_a: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_w && op_w == CPF_OP_DEC_SKIP && tgt_w == 2'b01
      |=> ptr_low_reg == 8'($past(ptr_low_reg) - 8'h01))
    else $error("Pointer byte step wrong.");
  opt_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      !opt_reg[CPF_CTRL_OPT_HIGH] ##1 !opt_reg[CPF_CTRL_OPT_HIGH]
      |-> !high_reg)
    else $error("High undervolt flag set without option.");
  mid_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      !opt_reg[CPF_CTRL_OPT_MID] ##1 !opt_reg[CPF_CTRL_OPT_MID]
      |-> !mid_reg)
    else $error("Middle undervolt flag set without option.");

endmodule

// ---- cpf_tb.sv ----
// Self-checking testbench for the accumulator, program counter and flag datapath.
`timescale 1ns/1ps
module testbench;
  import cpf_pkg::*;
  // ********************************************************************
  // Signals and counters.
  // ********************************************************************
  localparam logic [31:0] ALL = 32'hffffffff;
  logic        pclk;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [1:0]  reset_cause;
  logic        undervolt_high_det;
  logic        undervolt_mid_det;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [14:0] instr_pointer;
  logic [7:0]  work_reg_a;
  logic [31:0] rdata;
  logic        err;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cycles = 0;

  cpf_core #(.ADDR_W(12)) dut_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .reset_cause(reset_cause),
    .undervolt_high_det(undervolt_high_det), .undervolt_mid_det(undervolt_mid_det),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_pointer(instr_pointer), .work_reg_a(work_reg_a)
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ********************************************************************
  // Bus tasks and checks.
  // ********************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    tests_run++;
    if (seen !== expd) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n == 50) begin
      check(32'h0, 32'h1);
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    xfer(1'b1, {2'b00, idx, 2'b00}, d, 4'hf);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, {2'b00, idx, 2'b00}, 32'h0, 4'hf);
    check(rdata & m, e);
  endtask

  task automatic run(input logic [3:0] op, input logic [7:0] v, input logic [2:0] b,
                     input logic [1:0] t, input logic [6:0] dh, input logic [14:0] npc);
    wr(CPF_IDX_CMD, {1'b0, dh, 4'h0, op, 2'b00, t, 1'b0, b, v});
    rd(CPF_IDX_PC, ALL, {17'h0, npc});
  endtask

  task automatic do_reset(input logic [1:0] c);
    reset_cause <= c;
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ********************************************************************
  // Test sequence.
  // ********************************************************************
  initial begin
    presetn = 1'b0;
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    reset_cause = 2'b00;
    undervolt_high_det = 1'b0;
    undervolt_mid_det = 1'b0;
    for (int i = 0; i < 4; i++) begin
      do_reset(i[1:0]);
      rd(CPF_IDX_FLAGS, ALL, {24'h0, i[1:0], 6'h00});
      rd(CPF_IDX_PC, ALL, 32'h0);
    end
    $display("test reset done");
    wr(CPF_IDX_ACC, 32'h1a5);
    rd(CPF_IDX_ACC, ALL, 32'ha5);
    wr(CPF_IDX_PTR_HIGH, 32'h3c);
    rd(CPF_IDX_PTR_HIGH, ALL, 32'h3c);
    wr(CPF_IDX_PTR_LOW, 32'hc3);
    rd(CPF_IDX_PTR_LOW, ALL, 32'hc3);
    xfer(1'b1, {2'b00, CPF_IDX_ACC, 2'b00}, 32'h11, 4'he);
    xfer(1'b0, 12'h140, 32'h0, 4'hf);
    check({31'h0, err}, 32'h1);
    check(rdata, 32'h0);
    xfer(1'b1, 12'h101, 32'h22, 4'hf);
    check({31'h0, err}, 32'h1);
    @(posedge pclk);
    check({24'h0, work_reg_a}, 32'ha5);
    $display("test registers done");
    wr(CPF_IDX_PC, 32'hffff);
    rd(CPF_IDX_PC, ALL, 32'h7fff);
    check({17'h0, instr_pointer}, 32'h7fff);
    run(CPF_OP_NOP, 8'h00, 3'd0, 2'd0, 7'h00, 15'h0000);
    run(CPF_OP_JUMP, 8'hbc, 3'd0, 2'd0, 7'h7a, 15'h7abc);
    wr(CPF_IDX_ACC, 32'h10);
    run(CPF_OP_ADD_PAGE, 8'h00, 3'd0, 2'd0, 7'h00, 15'h7acc);
    wr(CPF_IDX_PC, 32'h12f8);
    run(CPF_OP_ADD_PAGE, 8'h00, 3'd0, 2'd0, 7'h00, 15'h1208);
    $display("test counter done");
    wr(CPF_IDX_PC, 32'h0100);
    wr(CPF_IDX_ACC, 32'h12);
    run(CPF_OP_CMP_SKIP, 8'h12, 3'd0, 2'd0, 7'h00, 15'h0102);
    rd(CPF_IDX_FLAGS, 32'h05, 32'h05);
    run(CPF_OP_CMP_SKIP, 8'h13, 3'd0, 2'd0, 7'h00, 15'h0103);
    rd(CPF_IDX_FLAGS, 32'h05, 32'h00);
    wr(CPF_IDX_ACC, 32'hff);
    run(CPF_OP_INC_SKIP, 8'h00, 3'd0, 2'd0, 7'h00, 15'h0105);
    rd(CPF_IDX_ACC, ALL, 32'h00);
    run(CPF_OP_INC_SKIP, 8'h00, 3'd0, 2'd0, 7'h00, 15'h0106);
    wr(CPF_IDX_PTR_LOW, 32'h00);
    run(CPF_OP_DEC_SKIP, 8'h00, 3'd0, 2'd1, 7'h00, 15'h0108);
    rd(CPF_IDX_PTR_LOW, ALL, 32'hff);
    run(CPF_OP_DEC_SKIP, 8'h00, 3'd0, 2'd1, 7'h00, 15'h0109);
    run(CPF_OP_BT0_SKIP, 8'h00, 3'd0, 2'd1, 7'h00, 15'h010b);
    run(CPF_OP_BT1_SKIP, 8'h00, 3'd0, 2'd1, 7'h00, 15'h010c);
    run(CPF_OP_BT1_SKIP, 8'h00, 3'd7, 2'd1, 7'h00, 15'h010e);
    run(CPF_OP_BT0_SKIP, 8'h00, 3'd7, 2'd1, 7'h00, 15'h010f);
    $display("test skips done");
    wr(CPF_IDX_FLAGS, 32'hc0);
    wr(CPF_IDX_ACC, 32'h0f);
    run(CPF_OP_ADD, 8'h01, 3'd0, 2'd0, 7'h00, 15'h0110);
    rd(CPF_IDX_ACC, ALL, 32'h10);
    rd(CPF_IDX_FLAGS, 32'h07, 32'h02);
    wr(CPF_IDX_ACC, 32'hf0);
    run(CPF_OP_ADD, 8'h10, 3'd0, 2'd0, 7'h00, 15'h0111);
    rd(CPF_IDX_FLAGS, 32'h07, 32'h05);
    wr(CPF_IDX_ACC, 32'h33);
    run(CPF_OP_SUB, 8'h11, 3'd0, 2'd0, 7'h00, 15'h0112);
    rd(CPF_IDX_ACC, ALL, 32'h22);
    rd(CPF_IDX_FLAGS, 32'h07, 32'h06);
    wr(CPF_IDX_ACC, 32'h01);
    run(CPF_OP_SUB, 8'h02, 3'd0, 2'd0, 7'h00, 15'h0113);
    rd(CPF_IDX_FLAGS, 32'h05, 32'h00);
    wr(CPF_IDX_FLAGS, 32'hc0);
    wr(CPF_IDX_ACC, 32'h81);
    run(CPF_OP_RLC, 8'h00, 3'd0, 2'd0, 7'h00, 15'h0114);
    rd(CPF_IDX_ACC, ALL, 32'h02);
    rd(CPF_IDX_FLAGS, 32'h04, 32'h04);
    wr(CPF_IDX_ACC, 32'hf0);
    run(CPF_OP_AND, 8'h0f, 3'd0, 2'd0, 7'h00, 15'h0115);
    rd(CPF_IDX_FLAGS, 32'h01, 32'h01);
    run(CPF_OP_MOV_ACC, 8'h5a, 3'd0, 2'd0, 7'h00, 15'h0116);
    rd(CPF_IDX_ACC, ALL, 32'h5a);
    run(4'hf, 8'h00, 3'd0, 2'd0, 7'h00, 15'h0117);
    rd(CPF_IDX_LAST, ALL, 32'h0f);
    $display("test arithmetic done");
    @(posedge pclk);
    undervolt_high_det <= 1'b1;
    undervolt_mid_det <= 1'b1;
    wr(CPF_IDX_CTRL, 32'h1);
    rd(CPF_IDX_FLAGS, 32'h30, 32'h20);
    wr(CPF_IDX_CTRL, 32'h2);
    rd(CPF_IDX_FLAGS, 32'h30, 32'h10);
    wr(CPF_IDX_CTRL, 32'h0);
    rd(CPF_IDX_FLAGS, 32'h30, 32'h00);
    @(posedge pclk);
    undervolt_high_det <= 1'b0;
    undervolt_mid_det <= 1'b0;
    wr(CPF_IDX_CTRL, 32'h3);
    wr(CPF_IDX_FLAGS, 32'hff);
    rd(CPF_IDX_FLAGS, ALL, 32'hc7);
    wr(CPF_IDX_FLAGS, 32'h40);
    rd(CPF_IDX_FLAGS, 32'hc0, 32'h40);
    $display("test flags done");
    stop_test();
  end
endmodule
